// ---- ess_regs.vh ----
`ifndef ESS_REGS_VH
`define ESS_REGS_VH
// Frame layout
`define ESS_FRAME_BITS      16
`define ESS_CNT_W           5
`define ESS_RW_BIT          15
`define ESS_PAR_BIT         0
`define ESS_EF_BIT          1
`define ESS_ALM_LO_BIT      14
`define ESS_ALM_HI_BIT      15
// Register locations (14-bit address field)
`define ESS_ADDR_NOP        14'h0000
`define ESS_ADDR_CLR_EF     14'h3380
`define ESS_ADDR_SW_RESET   14'h3C00
`define ESS_ADDR_MASTER_RST 14'h33A5
`define ESS_ADDR_AGC        14'h3FF8
`define ESS_ADDR_ANGLE      14'h3FFF
`define ESS_ADDR_STATUS     14'h335A
`define ESS_ADDR_SYSCFG1    14'h3F20
// Error status word bit positions
`define ESS_ST_PARITY       0
`define ESS_ST_CLKCNT       1
`define ESS_ST_ADDR         2
`define ESS_ST_HANDSHAKE    4
`define ESS_ST_BUSY         5
`define ESS_ST_HALL_OV      8
`define ESS_ST_SOLVER_OV    9
`define ESS_ST_RANGE        10
`define ESS_ST_DSP_LO       11
`define ESS_ST_DSP_HI       12
`define ESS_ST_RESET        14'h0000
`define ESS_ST_SOFT_MASK    14'h0007
// Software reset data: spi-reset bit
`define ESS_RES_SPI_BIT     6
// Gain limits and reset
`define ESS_AGC_MIN         6'h00
`define ESS_AGC_MAX         6'h3F
`define ESS_AGC_RESET       6'h20
// Identity code is arbitrary
`define ESS_CHIP_ID         3'h5
`define ESS_RESOLUTION      2'h1
`endif

// ---- ess_sync.v ----
`timescale 1ns/1ps
// Two-flop synchroniser, one per bit
module ess_sync #(
	parameter W = 1
) (
	input  wire         clk_i,
	input  wire         rst_i,
	input  wire         ce_i,
	input  wire [W-1:0] d_i,
	output wire [W-1:0] q_o
);
	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : g_bit
			reg meta_r;
			reg sync_r;
			always @(posedge clk_i) begin
				if (rst_i) begin
					meta_r <= 1'b0;
					sync_r <= 1'b0;
				end else if (ce_i) begin
					meta_r <= d_i[g];
					sync_r <= meta_r;
				end
			end
			assign q_o[g] = sync_r;
		end
	endgenerate
endmodule // ess_sync

// ---- ess_spi_monitor.v ----
`timescale 1ns/1ps
`include "ess_regs.vh"
module ess_spi_monitor (
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       ce_i,
	input  wire       sck_i,
	input  wire       ss_n_i,
	input  wire       mosi_i,
	output wire       miso_o,
	output wire       miso_oe_o,
	input  wire       wire_mode_i,
	input  wire [5:0] gain_level_i,
	input  wire       measure_done_i,
	input  wire       sleep_i,
	input  wire       hall_overflow_i,
	input  wire       solver_overflow_i,
	input  wire       range_drop_i,
	input  wire [9:0] angle_i,
	output wire       angle_request_o,
	output wire       four_wire_o,
	output wire       soft_reset_o,
	output wire [5:0] gain_setting_o,
	output wire [13:0] fault_status_o
);
	// clock and select come from the master, sampled here
	wire [2:0] pin_s;
	ess_sync #(.W(3)) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.d_i   ({sck_i, ~ss_n_i, mosi_i}),
		.q_o   (pin_s)
	);
	// Select passes inverted so the synchroniser's reset value means idle, no false frame
	wire sck_s  = pin_s[2];
	wire ss_n_s = ~pin_s[1];
	wire mosi_s = pin_s[0];

	reg                   sck_d_r;
	reg                   ss_d_r;
	reg [`ESS_CNT_W-1:0]  bit_cnt_r;
	reg [15:0]            rx_r;
	reg [15:0]            tx_r;
	reg [15:0]            resp_r;
	reg                   miso_r;
	reg                   frame_fault_flag_r;
	reg                   parity_fault_r;
	reg                   clock_count_fault_r;
	reg                   bad_location_fault_r;
	reg                   measure_handshake_flag_r;
	reg                   hall_converter_overflow_r;
	reg                   solver_overflow_r;
	reg                   current_source_range_fault_r;
	reg                   four_wire_r;
	reg                   mode_armed_r;
	reg                   soft_reset_r;
	reg                   soft_pending_r;
	reg                   soft_spi_r;
	reg                   angle_req_r;
	reg [5:0]             gain_r;
	reg [13:0]            wr_addr_r;
	reg                   wr_pending_r;

	wire sck_fall = sck_d_r & ~sck_s;
	wire sck_rise = ~sck_d_r & sck_s;
	wire ss_rise  = ~ss_d_r & ss_n_s;
	wire active   = ~ss_n_s;

	wire dsp_weak_field_alarm   = (gain_level_i <= `ESS_AGC_MIN);
	wire dsp_strong_field_alarm = (gain_level_i >= `ESS_AGC_MAX);

	wire [13:0] status_word = {1'b0,
		dsp_strong_field_alarm,
		dsp_weak_field_alarm,
		current_source_range_fault_r,
		solver_overflow_r,
		hall_converter_overflow_r,
		2'b00,
		~sleep_i,
		measure_handshake_flag_r,
		1'b0,
		bad_location_fault_r,
		clock_count_fault_r,
		parity_fault_r};

	// Flags that count as "an error occurred"; busy is a state, not a fault
	wire any_error = parity_fault_r | clock_count_fault_r | bad_location_fault_r |
		hall_converter_overflow_r | solver_overflow_r | current_source_range_fault_r |
		dsp_weak_field_alarm | dsp_strong_field_alarm;

	reg gain_upper_alarm;
	reg gain_lower_alarm;
	always @* begin
		if (frame_fault_flag_r | parity_fault_r | clock_count_fault_r |
			bad_location_fault_r | hall_converter_overflow_r | solver_overflow_r |
			current_source_range_fault_r) begin
			gain_upper_alarm = 1'b1;
			gain_lower_alarm = 1'b1;
		end else if (dsp_weak_field_alarm) begin
			gain_upper_alarm = 1'b0;
			gain_lower_alarm = 1'b1;
		end else if (dsp_strong_field_alarm) begin
			gain_upper_alarm = 1'b1;
			gain_lower_alarm = 1'b0;
		end else begin
			gain_upper_alarm = 1'b0;
			gain_lower_alarm = 1'b0;
		end
	end

	// Frame decode at select release
	wire        full_frame = (bit_cnt_r == `ESS_FRAME_BITS);
	wire        par_ok     = ~(^rx_r); // even parity over whole frame
	wire        is_read    = rx_r[`ESS_RW_BIT];
	wire [13:0] addr       = rx_r[14:1];
	wire        addr_known = (addr == `ESS_ADDR_NOP) || (addr == `ESS_ADDR_CLR_EF) ||
		(addr == `ESS_ADDR_SW_RESET) || (addr == `ESS_ADDR_MASTER_RST) ||
		(addr == `ESS_ADDR_AGC) || (addr == `ESS_ADDR_ANGLE) ||
		(addr == `ESS_ADDR_STATUS) || (addr == `ESS_ADDR_SYSCFG1);
	wire        good       = full_frame & par_ok;
	wire        do_clear   = good & ~wr_pending_r & is_read & (addr == `ESS_ADDR_CLR_EF);
	wire        bad_cmd    = good & ~wr_pending_r & ~addr_known;

	// Read data for the next frame
	reg [13:0] rd_data;
	always @* begin
		case (addr)
			`ESS_ADDR_ANGLE:   rd_data = {gain_upper_alarm, gain_lower_alarm, 2'b00, angle_i};
			`ESS_ADDR_AGC:     rd_data = {8'h00, gain_r};
			`ESS_ADDR_STATUS:  rd_data = status_word;
			`ESS_ADDR_SYSCFG1: rd_data = {`ESS_RESOLUTION, `ESS_CHIP_ID, 9'h000};
			default:           rd_data = 14'h0000;
		endcase
	end

	function [15:0] with_par;
		input [14:0] v;
		begin
			with_par = {v, ^v};
		end
	endfunction

	always @(posedge clk_i) begin
		if (rst_i) begin
			sck_d_r                      <= 1'b0;
			ss_d_r                       <= 1'b1;
			bit_cnt_r                    <= {`ESS_CNT_W{1'b0}};
			rx_r                         <= 16'h0000;
			tx_r                         <= 16'h0000;
			resp_r                       <= 16'h0000;
			miso_r                       <= 1'b0;
			frame_fault_flag_r           <= 1'b0;
			parity_fault_r               <= 1'b0;
			clock_count_fault_r          <= 1'b0;
			bad_location_fault_r         <= 1'b0;
			measure_handshake_flag_r     <= 1'b0;
			hall_converter_overflow_r    <= 1'b0;
			solver_overflow_r            <= 1'b0;
			current_source_range_fault_r <= 1'b0;
			four_wire_r                  <= 1'b0;
			mode_armed_r                 <= 1'b1;
			soft_reset_r                 <= 1'b0;
			soft_pending_r               <= 1'b0;
			soft_spi_r                   <= 1'b0;
			angle_req_r                  <= 1'b0;
			gain_r                       <= `ESS_AGC_RESET;
			wr_addr_r                    <= 14'h0000;
			wr_pending_r                 <= 1'b0;
		end else if (ce_i) begin
			sck_d_r      <= sck_s;
			ss_d_r       <= ss_n_s;
			soft_reset_r <= 1'b0;
			angle_req_r  <= 1'b0;
			// wire mode caught after release of power-on or soft reset
			if (mode_armed_r) begin
				four_wire_r  <= wire_mode_i;
				mode_armed_r <= 1'b0;
			end
			if (hall_overflow_i)
				hall_converter_overflow_r <= 1'b1;
			if (solver_overflow_i)
				solver_overflow_r <= 1'b1;
			if (range_drop_i)
				current_source_range_fault_r <= 1'b1;
			// deadlock leaves the flag high since done never comes
			if (measure_done_i)
				measure_handshake_flag_r <= 1'b0;
			if (active && sck_fall) begin
				rx_r      <= {rx_r[14:0], mosi_s};
				bit_cnt_r <= (bit_cnt_r == 5'h1F) ? bit_cnt_r : bit_cnt_r + 5'h01;
			end
			if (active && sck_rise) begin
				miso_r <= tx_r[15];
				tx_r   <= {tx_r[14:0], 1'b0};
			end
			if (ss_d_r && !ss_n_s) begin
				tx_r      <= resp_r;
				bit_cnt_r <= {`ESS_CNT_W{1'b0}};
			end
			if (ss_rise) begin
				bit_cnt_r <= {`ESS_CNT_W{1'b0}};
				if (!full_frame)
					clock_count_fault_r <= 1'b1;
				if (full_frame && !par_ok)
					parity_fault_r <= 1'b1;
				if (bad_cmd)
					bad_location_fault_r <= 1'b1;
				// set wins over clear in the same frame
				if (!good || bad_cmd)
					frame_fault_flag_r <= 1'b1;
				else if (do_clear)
					frame_fault_flag_r <= 1'b0;
				if (good && wr_pending_r) begin
					// Data frame of a write
					wr_pending_r <= 1'b0;
					resp_r <= with_par({1'b0, rx_r[14:1]});
					if (wr_addr_r == `ESS_ADDR_AGC)
						gain_r <= rx_r[6:1];
					if (wr_addr_r == `ESS_ADDR_SW_RESET) begin
						soft_pending_r <= 1'b1;
						soft_spi_r     <= rx_r[`ESS_RES_SPI_BIT];
					end
				end else if (good && !bad_cmd) begin
					if (do_clear) begin
						resp_r <= 16'h0000;
						parity_fault_r       <= 1'b0;
						clock_count_fault_r  <= 1'b0;
						bad_location_fault_r <= 1'b0;
					end else if (is_read) begin
						// fault flag in bit 1 of every read answer except the clear-fault read, which answers all zeros
						resp_r <= {rd_data, frame_fault_flag_r,
							^{rd_data, frame_fault_flag_r}};
						if (addr == `ESS_ADDR_ANGLE) begin
							measure_handshake_flag_r <= 1'b1;
							angle_req_r              <= 1'b1;
						end
					end else begin
						resp_r <= 16'h0000;
						if (addr != `ESS_ADDR_NOP) begin
							wr_pending_r <= 1'b1;
							wr_addr_r    <= addr;
						end
					end
				end else begin
					wr_pending_r <= 1'b0;
				end
			end
			// Soft reset takes effect after its data frame closes
			if (soft_pending_r && ss_n_s) begin
				soft_pending_r <= 1'b0;
				soft_reset_r   <= 1'b1;
				mode_armed_r   <= 1'b1;
				gain_r         <= `ESS_AGC_RESET;
				// A fault arriving in the clear cycle still wins
				hall_converter_overflow_r    <= hall_overflow_i;
				solver_overflow_r            <= solver_overflow_i;
				current_source_range_fault_r <= range_drop_i;
				measure_handshake_flag_r     <= 1'b0;
				if (soft_spi_r) begin
					frame_fault_flag_r   <= 1'b0;
					parity_fault_r       <= 1'b0;
					clock_count_fault_r  <= 1'b0;
					bad_location_fault_r <= 1'b0;
					resp_r               <= 16'h0000;
				end
			end
		end
	end

	// MISO drives only inside a frame, and only in four-wire mode
	assign miso_o          = miso_r;
	assign miso_oe_o       = active & four_wire_r;
	assign angle_request_o = angle_req_r;
	assign four_wire_o     = four_wire_r;
	assign soft_reset_o    = soft_reset_r;
	assign gain_setting_o  = gain_r;
	assign fault_status_o  = status_word;
	wire unused_any = any_error;
endmodule // ess_spi_monitor

// ---- ess_spi_monitor_properties.sv ----
`timescale 1ns/1ps
module ess_spi_monitor_props (
	input wire        clk_i,
	input wire        rst_i,
	input wire        ss_n_i,
	input wire        sleep_i,
	input wire [5:0]  gain_level_i,
	input wire        hall_overflow_i,
	input wire        range_drop_i,
	input wire        measure_done_i,
	input wire        miso_oe_o,
	input wire        four_wire_o,
	input wire        soft_reset_o,
	input wire        angle_request_o,
	input wire [13:0] fault_status_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_reserved_zero: assert property (
		{fault_status_o[13], fault_status_o[7:6], fault_status_o[3]} == 4'h0)
		else $error("reserved status bit set");
	chk_busy_sleep: assert property (
		$stable(sleep_i)[*3] |-> fault_status_o[5] == !sleep_i) else $error("busy bit wrong");
	chk_oe_select: assert property (
		ss_n_i[*3] |-> !miso_oe_o) else $error("miso driven while deselected");
	chk_weak_alarm: assert property (
		(gain_level_i == 6'h00)[*3] |-> fault_status_o[11]) else $error("weak alarm missing");
	chk_hall_flag: assert property (
		hall_overflow_i |-> ##[1:3] fault_status_o[8]) else $error("converter flag missing");
	chk_range_flag: assert property (
		range_drop_i |-> ##[1:3] fault_status_o[10]) else $error("range flag missing");
	// Mode may only move just after a reset of either kind
	chk_mode_hold: assert property (
		!$past(rst_i) && !soft_reset_o && !$past(soft_reset_o) && !$past(soft_reset_o, 2)
		|=> $stable(four_wire_o)) else $error("wire mode changed");
	chk_shake_set: assert property (
		angle_request_o |-> ##[0:2] fault_status_o[4]) else $error("handshake not raised");
	chk_shake_clear: assert property (
		measure_done_i && !angle_request_o |-> ##[1:3] !fault_status_o[4])
		else $error("handshake not cleared");
	cover property (angle_request_o);
	cover property (soft_reset_o);
	cover property (fault_status_o[1]);
endmodule // ess_spi_monitor_props
bind ess_spi_monitor ess_spi_monitor_props i_ess_spi_monitor_props (.clk_i, .rst_i, .ss_n_i,
	.sleep_i, .gain_level_i, .hall_overflow_i, .range_drop_i, .measure_done_i, .miso_oe_o,
	.four_wire_o, .soft_reset_o, .angle_request_o, .fault_status_o);

// ---- ess_spi_host.sv ----
`timescale 1ns/1ps
module ess_spi_host (
	input  wire clk_i,
	output reg  sck_o,
	output reg  ss_n_o,
	output reg  mosi_o,
	input  wire miso_i,
	input  wire miso_oe_i
);
	initial begin
		sck_o = 1'b0;
		ss_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	// SCK idles low; a released MISO reads as the inverse of the last bit
	task xfer(input [15:0] tx, input integer n, output [15:0] rx);
		integer i;
		begin
			rx = 16'h0000;
			@(posedge clk_i);
			ss_n_o <= 1'b0;
			repeat (4) @(posedge clk_i);
			for (i = 0; i < n; i = i + 1) begin
				sck_o <= 1'b1;
				mosi_o <= tx[15 - (i % 16)];
				repeat (4) @(posedge clk_i);
				sck_o <= 1'b0;
				repeat (4) @(posedge clk_i);
				rx = {rx[14:0], miso_oe_i ? miso_i : ~rx[0]};
			end
			ss_n_o <= 1'b1;
			mosi_o <= ~mosi_o;
			repeat (8) @(posedge clk_i);
		end
	endtask
endmodule // ess_spi_host

// ---- ess_spi_monitor_bench.sv ----
`timescale 1ns/1ps
`include "ess_regs.vh"
module ess_spi_monitor_bench;
	reg         clk_i  = 1'b0;
	reg         rst_i  = 1'b1;
	reg         wmode  = 1'b1;
	reg  [5:0]  gain   = 6'h10;
	reg         done   = 1'b0;
	reg         sleep  = 1'b1;
	reg  [2:0]  ovf    = 3'h0;
	reg  [9:0]  angle  = 10'h2A5;
	reg         saw_sr = 1'b0;
	reg  [15:0] r;
	wire        sck, ss_n, mosi, miso, oe, areq, fw, sr;
	wire [5:0]  gset;
	wire [13:0] st;
	integer     n_fail = 0;
	integer     checks = 0;
	always #20 clk_i = ~clk_i;
	// The pulse may land inside a frame's tail, so latch it
	always @(posedge clk_i) if (sr) saw_sr <= 1'b1;
	ess_spi_monitor i_ess_spi_monitor (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .sck_i(sck),
		.ss_n_i(ss_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(oe), .wire_mode_i(wmode),
		.gain_level_i(gain), .measure_done_i(done), .sleep_i(sleep), .hall_overflow_i(ovf[0]),
		.solver_overflow_i(ovf[1]), .range_drop_i(ovf[2]), .angle_i(angle),
		.angle_request_o(areq), .four_wire_o(fw), .soft_reset_o(sr), .gain_setting_o(gset),
		.fault_status_o(st));
	ess_spi_host i_ess_spi_host (.clk_i(clk_i), .sck_o(sck), .ss_n_o(ss_n), .mosi_o(mosi),
		.miso_i(miso), .miso_oe_i(oe));
	function [15:0] mk(input [14:0] v);
		mk = {v, ^v};
	endfunction
	task check(input [15:0] s, input [15:0] e);
		begin
			checks = checks + 1;
			if (s !== e) begin
				n_fail = n_fail + 1;
				$display("FAIL %0t seen %h expected %h", $time, s, e);
			end
		end
	endtask
	task xf(input [15:0] t, input integer n);
		i_ess_spi_host.xfer(t, n, r);
	endtask
	task rd(input [13:0] a);
		begin
			xf(mk({1'b1, a}), 16);
			xf(16'h0000, 16);
		end
	endtask
	task clr;
		begin
			rd(`ESS_ADDR_CLR_EF);
			check(r, 16'h0000);
			check(16'(st[2:0]), 16'h0000);
		end
	endtask
	task t_reset;
		begin
			check(16'(st), 16'h0000);
			check(16'(gset), 16'h0020);
			check(16'(fw), 16'h0001);
			@(posedge clk_i);
			sleep <= 1'b0;
			repeat (4) @(posedge clk_i);
			check(16'(st), 16'h0020);
			@(posedge clk_i);
			sleep <= 1'b1;
			wmode <= 1'b0;
			$display("reset test done");
		end
	endtask
	task t_gain;
		integer k;
		begin
			for (k = 0; k < 3; k = k + 1) begin
				@(posedge clk_i);
				gain <= (k == 0) ? 6'h10 : (k == 1) ? 6'h00 : 6'h3F;
				rd(`ESS_ADDR_ANGLE);
				check(r, mk({k == 2, k == 1, 2'b00, angle, 1'b0}));
			end
			check(16'(st[12:11]), 16'h0002);
			@(posedge clk_i);
			gain <= 6'h10;
			$display("gain test done");
		end
	endtask
	task t_angle;
		begin
			xf(mk({1'b1, `ESS_ADDR_ANGLE}), 16);
			check(16'(st[4]), 16'h0001);
			@(posedge clk_i);
			done <= 1'b1;
			@(posedge clk_i);
			done <= 1'b0;
			repeat (3) @(posedge clk_i);
			check(16'(st[4]), 16'h0000);
			xf(16'h0000, 16);
			check(16'(r[13:1]), {5'h00, angle, 1'b0});
			$display("angle test done");
		end
	endtask
	task t_write;
		begin
			xf(mk({1'b0, `ESS_ADDR_AGC}), 16);
			xf(mk({9'h000, 6'h15}), 16);
			check(16'(gset), 16'h0015);
			rd(`ESS_ADDR_AGC);
			check(r, mk({14'h0015, 1'b0}));
			$display("write test done");
		end
	endtask
	task t_parity;
		begin
			xf(mk({1'b1, `ESS_ADDR_AGC}) ^ 16'h0001, 16);
			check(16'(st[0]), 16'h0001);
			rd(`ESS_ADDR_ANGLE);
			check(16'({r[15:14], r[1]}), 16'h0007);
			clr;
			rd(`ESS_ADDR_AGC);
			check(r, mk({14'h0015, 1'b0}));
			$display("parity test done");
		end
	endtask
	task t_count;
		integer n;
		begin
			for (n = 15; n < 18; n = n + 2) begin
				xf(16'h0000, n);
				check(16'(st[1]), 16'h0001);
				clr;
			end
			rd(14'h1234);
			check(16'(st[2]), 16'h0001);
			clr;
			$display("count and address test done");
		end
	endtask
	task t_soft;
		begin
			@(posedge clk_i);
			ovf <= 3'h7;
			@(posedge clk_i);
			ovf <= 3'h0;
			repeat (4) @(posedge clk_i);
			check(16'(st[10:8]), 16'h0007);
			check(16'(fw), 16'h0001);
			xf(mk({1'b0, `ESS_ADDR_SW_RESET}), 16);
			xf(mk(15'h0020), 16);
			check(16'(saw_sr), 16'h0001);
			check(16'(fw), 16'h0000);
			check(16'(st[10:8]), 16'h0000);
			xf(16'h0000, 15);
			check(16'(st[1]), 16'h0001);
			@(posedge clk_i);
			rst_i <= 1'b1;
			repeat (3) @(posedge clk_i);
			rst_i <= 1'b0;
			repeat (4) @(posedge clk_i);
			check(16'(st), 16'h0000);
			check(16'(fw), 16'h0000);
			$display("soft reset test done");
		end
	endtask
	task give_verdict;
		begin
			$display("checks %0d failures %0d", checks, n_fail);
			if (n_fail == 0 && checks > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		t_reset;
		t_gain;
		t_angle;
		t_write;
		t_parity;
		t_count;
		t_soft;
		give_verdict;
	end
	initial begin
		#2000000;
		n_fail = n_fail + 1;
		give_verdict;
	end
endmodule // ess_spi_monitor_bench
